// ---- include/cmp_cap_cfg.svh ----
// Purpose: Offsets, field positions and reset values of the compare and
//          capture control block.
// Assumes: Word-indexed register port, 16-bit data in the low bits.
// Notes:   Definitions only.
`ifndef CMP_CAP_CFG_SVH
`define CMP_CAP_CFG_SVH

`define ADDR_COMPARE_CONTROL 4'h0
`define ADDR_CAPTURE_CONTROL 4'h1
`define ADDR_COMPARE_VALUE_LO 4'h2
`define ADDR_COMPARE_VALUE_HI 4'h3
`define ADDR_IRQ_STATUS      4'h4
`define ADDR_IRQ_MASK        4'h5
`define ADDR_ACTIVE_CMP_LO   4'h6
`define ADDR_ACTIVE_CMP_HI   4'h7

`define BIT_SHADOW_ON        15
`define BIT_SHADOW_LOAD_SEL  14
`define BIT_SYNC_POLARITY    13
`define BIT_COMPARE_ON       12
`define BIT_CAPTURE_ON       15
`define SYNC_WIDTH_MSB       11
`define CLK_PRESCALE_MSB     6
`define CLK_PRESCALE_LSB     4
`define UNIT_PRESCALE_MSB    3
`define CAP_WRITABLE_MASK    16'h807f
`define COMPARE_CONTROL_RST  16'h0000
`define CAPTURE_CONTROL_RST  16'h0000

`define IRQ_BIT_MATCH        0
`define IRQ_BIT_LOAD         1
`define IRQ_BIT_UNIT_EVENT   2
`define IRQ_WIDTH            3

`define PULSE_QUANTUM        4
`define UNIT_POSITION_PRESCALE_MAX_CODE        4'hb

`endif

// ---- include/cmp_cap_pkg.sv ----
// Purpose: Types shared by the compare and capture control block.
// Assumes: Nothing.
// Notes:   Constants live in cmp_cap_cfg.svh.
package cmp_cap_pkg;
	typedef enum logic [0:0] {
		idle_type_s,
		pulse_type_s
	} sync_state_type;
endpackage

// ---- core/sync_pulse_stretcher.sv ----
// Purpose: Stretches a compare match into a sync pulse of (width+1)*4 cycles.
// Assumes: width is sampled at the start of each pulse.
// Notes:   A match during a pulse is absorbed, the pulse is not restarted.
`timescale 1ns/100ps
`include "cmp_cap_cfg.svh"
module sync_pulse_stretcher #(
	parameter int WIDTH_BITS = 12
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  start_i,
	input  wire logic [WIDTH_BITS-1:0] width_i,
	output logic                       active_o
);
	localparam int CNT_BITS = WIDTH_BITS + 2;
	logic [CNT_BITS-1:0]         remain;
	cmp_cap_pkg::sync_state_type state;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state  <= cmp_cap_pkg::idle_type_s;
			remain <= '0;
		end else begin
			case (state)
			cmp_cap_pkg::idle_type_s: begin
				if (start_i) begin
					state  <= cmp_cap_pkg::pulse_type_s;
					remain <= CNT_BITS'((32'(width_i) + 1) *
						`PULSE_QUANTUM - 1);
				end
			end
			cmp_cap_pkg::pulse_type_s: begin
				if (remain == '0)
					state <= cmp_cap_pkg::idle_type_s;
				else
					remain <= remain - 1'b1;
			end
			default: state <= cmp_cap_pkg::idle_type_s;
			endcase
		end
	end

	assign active_o = (state == cmp_cap_pkg::pulse_type_s);

	pulse_len_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(start_i && !active_o && width_i == '0) |=>
		active_o [*4] ##1 !active_o)
		else $error("sync pulse length wrong");
endmodule // sync_pulse_stretcher

// ---- core/event_prescaler.sv ----
// Purpose: Divides the system clock and the quadrature clock pulses.
// Assumes: quad_pulse_i is a one-cycle pulse per quadrature clock edge.
// Notes:   Both counters hold in reset while the capture unit is off.
`timescale 1ns/100ps
`include "cmp_cap_cfg.svh"
module event_prescaler (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       enable_i,
	input  wire logic [2:0] clk_code_i,
	input  wire logic [3:0] unit_code_i,
	input  wire logic       quad_pulse_i,
	output logic            cap_tick_o,
	output logic            unit_event_o
);
	logic [6:0]  clk_div;
	logic [10:0] unit_div;
	logic [6:0]  clk_lim;
	logic [10:0] unit_lim;
	logic [3:0]  unit_code;

	// Codes above the top ratio saturate at divide-by-2048
	assign unit_code = (unit_code_i > `UNIT_POSITION_PRESCALE_MAX_CODE) ?
		`UNIT_POSITION_PRESCALE_MAX_CODE : unit_code_i;
	assign clk_lim   = 7'((8'h01 << clk_code_i) - 8'h01);
	assign unit_lim  = 11'((12'h001 << unit_code) - 12'h001);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_div    <= '0;
			cap_tick_o <= 1'b0;
		end else if (!enable_i) begin
			clk_div    <= '0;
			cap_tick_o <= 1'b0;
		end else begin
			cap_tick_o <= (clk_div >= clk_lim);
			clk_div    <= (clk_div >= clk_lim) ? '0 : clk_div + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unit_div     <= '0;
			unit_event_o <= 1'b0;
		end else if (!enable_i) begin
			unit_div     <= '0;
			unit_event_o <= 1'b0;
		end else begin
			unit_event_o <= quad_pulse_i && (unit_div >= unit_lim);
			if (quad_pulse_i)
				unit_div <= (unit_div >= unit_lim) ? '0 : unit_div + 1'b1;
		end
	end

	cap_off_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!enable_i |=> !cap_tick_o && !unit_event_o)
		else $error("prescaler ticks while capture off");
	div1_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(enable_i && clk_code_i == 3'h0) [*2] |=> cap_tick_o)
		else $error("divide-by-1 tick missing");
endmodule // event_prescaler

// ---- core/compare_sync_capture_ctrl.sv ----
// Purpose: Compare sync output and capture prescaler control with registers.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   Position count and quadrature pulses come from outside.
//
// Overview of operation
// - With shadowing off a compare value write acts at once, else it waits in a shadow copy.
// - The shadow load select picks load at count zero (0) or at count equal compare (1).
// - The sync output is active high at polarity 0 and active low at 1, idle opposite.
// - The compare enable bit gates all compare match pulses.
// - The sync pulse lasts (width field plus one) times four system clocks.
// - The capture enable bit turns the capture prescalers on or off.
// - The capture timer clock is the system clock divided by two to the field value.
// - One unit position event per two to the field value quadrature pulses, max 2048.
// - A match of active compare value and position count fires the sync pulse and sets the match interrupt flag.
`timescale 1ns/100ps
`include "cmp_cap_cfg.svh"
module compare_sync_capture_ctrl #(
	parameter int POS_BITS = 32
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic [3:0]          addr_i,
	input  wire logic [15:0]         wdata_i,
	input  wire logic                wr_i,
	input  wire logic                rd_i,
	output logic      [15:0]         rdata_o,
	input  wire logic [POS_BITS-1:0] position_count_i,
	input  wire logic                quad_pulse_i,
	output logic                     sync_out_o,
	output logic                     match_o,
	output logic                     capture_tick_o,
	output logic                     unit_event_o,
	output logic                     irq_o
);
	logic [15:0]               compare_control;
	logic [15:0]               capture_control;
	logic [POS_BITS-1:0]       shadow_value;
	logic [POS_BITS-1:0]       compare_value;
	logic [`IRQ_WIDTH-1:0]     irq_status;
	logic [`IRQ_WIDTH-1:0]     irq_mask;
	logic [`IRQ_WIDTH-1:0]     irq_set;
	logic                      cmp_shadow_on;
	logic                      cmp_shadow_load_sel;
	logic                      sync_out_polarity;
	logic                      compare_unit_on;
	logic [11:0]               sync_pulse_width;
	logic                      capture_unit_on;
	logic                      eq_hit;
	logic                      eq_prev;
	logic                      zero_hit;
	logic                      load_event;
	logic                      pulse_active;
	logic                      next_match;
	logic [POS_BITS-1:0]       write_value;

	// Half-word merge keeps the untouched half of a split 32-bit write
	function automatic logic [POS_BITS-1:0] merge_half(
		input logic [POS_BITS-1:0] old_v,
		input logic [15:0]         part,
		input logic                high);
		logic [POS_BITS-1:0] res;
		res = old_v;
		if (high)
			res[31:16] = part;
		else
			res[15:0] = part;
		return res;
	endfunction

	// One decode for both halves keeps shadow and active paths in step
	function automatic logic is_cmp_value_addr(input logic [3:0] a);
		return (a == `ADDR_COMPARE_VALUE_LO) ||
			(a == `ADDR_COMPARE_VALUE_HI);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Control fields

	assign cmp_shadow_on       = compare_control[`BIT_SHADOW_ON];
	assign cmp_shadow_load_sel = compare_control[`BIT_SHADOW_LOAD_SEL];
	assign sync_out_polarity   = compare_control[`BIT_SYNC_POLARITY];
	assign compare_unit_on     = compare_control[`BIT_COMPARE_ON];
	assign sync_pulse_width    = compare_control[`SYNC_WIDTH_MSB:0];
	assign capture_unit_on     = capture_control[`BIT_CAPTURE_ON];

	////////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			compare_control <= `COMPARE_CONTROL_RST;
			capture_control <= `CAPTURE_CONTROL_RST;
			irq_mask        <= '0;
		end else if (wr_i) begin
			case (addr_i)
			`ADDR_COMPARE_CONTROL: compare_control <= wdata_i;
			`ADDR_CAPTURE_CONTROL:
				capture_control <= wdata_i & `CAP_WRITABLE_MASK;
			`ADDR_IRQ_MASK: irq_mask <= wdata_i[`IRQ_WIDTH-1:0];
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare value with optional shadow

	assign write_value = merge_half(cmp_shadow_on ? shadow_value :
		compare_value, wdata_i, addr_i == `ADDR_COMPARE_VALUE_HI);

	assign eq_hit   = (position_count_i == compare_value);
	assign zero_hit = (position_count_i == '0);
	// Equality is edge-detected so a standing match loads only once
	assign load_event = cmp_shadow_on && (cmp_shadow_load_sel ?
		(eq_hit && !eq_prev) : zero_hit);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shadow_value <= '0;
		end else if (wr_i && is_cmp_value_addr(addr_i) &&
			cmp_shadow_on) begin
			shadow_value <= write_value;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			compare_value <= '0;
		end else if (wr_i && is_cmp_value_addr(addr_i) &&
			!cmp_shadow_on) begin
			compare_value <= write_value;
		end else if (load_event) begin
			compare_value <= shadow_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Match detection and sync output

	// Edge detection: a count resting on the compare value fires once
	assign next_match = compare_unit_on && eq_hit && !eq_prev;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eq_prev <= 1'b0;
			match_o <= 1'b0;
		end else begin
			eq_prev <= eq_hit;
			match_o <= next_match;
		end
	end

	sync_pulse_stretcher #(
		.WIDTH_BITS (12)
	) u_stretch (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.start_i  (match_o),
		.width_i  (sync_pulse_width),
		.active_o (pulse_active)
	);

	// Registered so a polarity write cannot glitch the pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			sync_out_o <= 1'b0;
		else
			sync_out_o <= pulse_active ^ sync_out_polarity;
	end

	////////////////////////////////////////////////////////////////////////
	// Capture prescalers

	// Capture off clears both dividers, so a restart runs a full period
	event_prescaler u_presc (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.enable_i     (capture_unit_on),
		.clk_code_i   (capture_control[`CLK_PRESCALE_MSB:`CLK_PRESCALE_LSB]),
		.unit_code_i  (capture_control[`UNIT_PRESCALE_MSB:0]),
		.quad_pulse_i (quad_pulse_i),
		.cap_tick_o   (capture_tick_o),
		.unit_event_o (unit_event_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over write-one-to-clear

	always_comb begin
		irq_set = '0;
		irq_set[`IRQ_BIT_MATCH]      = match_o;
		irq_set[`IRQ_BIT_LOAD]       = load_event;
		irq_set[`IRQ_BIT_UNIT_EVENT] = unit_event_o;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			irq_status <= '0;
		else if (wr_i && addr_i == `ADDR_IRQ_STATUS)
			irq_status <= (irq_status & ~wdata_i[`IRQ_WIDTH-1:0]) | irq_set;
		else
			irq_status <= irq_status | irq_set;
	end

	// Level output: software clears the cause, not the line
	assign irq_o = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Register reads

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
			`ADDR_COMPARE_CONTROL:  rdata_o <= compare_control;
			`ADDR_CAPTURE_CONTROL:  rdata_o <= capture_control;
			// Shadow reads let software check a pending value before it loads
			`ADDR_COMPARE_VALUE_LO: rdata_o <= cmp_shadow_on ?
				shadow_value[15:0] : compare_value[15:0];
			`ADDR_COMPARE_VALUE_HI: rdata_o <= cmp_shadow_on ?
				shadow_value[31:16] : compare_value[31:16];
			`ADDR_IRQ_STATUS: rdata_o <= 16'(irq_status);
			`ADDR_IRQ_MASK:   rdata_o <= 16'(irq_mask);
			`ADDR_ACTIVE_CMP_LO: rdata_o <= compare_value[15:0];
			`ADDR_ACTIVE_CMP_HI: rdata_o <= compare_value[31:16];
			default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	imm_write_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && addr_i == `ADDR_COMPARE_VALUE_LO && !cmp_shadow_on) |=>
		compare_value[15:0] == $past(wdata_i))
		else $error("immediate compare write lost");
	imm_write_hi_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && addr_i == `ADDR_COMPARE_VALUE_HI && !cmp_shadow_on) |=>
		compare_value[31:16] == $past(wdata_i))
		else $error("immediate high compare write lost");
	shadow_take_lo_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && addr_i == `ADDR_COMPARE_VALUE_LO && cmp_shadow_on) |=>
		shadow_value[15:0] == $past(wdata_i))
		else $error("shadow low write lost");
	shadow_take_hi_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && addr_i == `ADDR_COMPARE_VALUE_HI && cmp_shadow_on) |=>
		shadow_value[31:16] == $past(wdata_i))
		else $error("shadow high write lost");
	shadow_hold_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(cmp_shadow_on && !load_event) |=>
		$stable(compare_value))
		else $error("active compare changed without load");

	zero_load_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(cmp_shadow_on && !cmp_shadow_load_sel && zero_hit && !wr_i) |=>
		compare_value == $past(shadow_value))
		else $error("zero load missed");
	eq_load_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(cmp_shadow_on && cmp_shadow_load_sel && eq_hit && !eq_prev) |=>
		compare_value == $past(shadow_value))
		else $error("equality load missed");
	load_irq_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		load_event |=> irq_status[`IRQ_BIT_LOAD])
		else $error("shadow load flag not set");

	sync_polarity_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$stable(sync_out_polarity) |=>
		sync_out_o == ($past(pulse_active) ^ $past(sync_out_polarity)))
		else $error("sync output level wrong");
	sync_idle_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!pulse_active |=> sync_out_o == $past(sync_out_polarity))
		else $error("sync idle level wrong");
	sync_active_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		pulse_active |=> sync_out_o != $past(sync_out_polarity))
		else $error("sync active level wrong");

	compare_off_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!compare_unit_on |=> !match_o)
		else $error("match while compare off");
	match_edge_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(compare_unit_on && eq_hit && !eq_prev) |=>
		match_o)
		else $error("compare match missed");
	match_single_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		match_o |=> !match_o)
		else $error("match pulse longer than one cycle");
	match_sync_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(match_o && !pulse_active) |=> pulse_active ##1 pulse_active)
		else $error("match did not start pulse");
	match_irq_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		match_o |=> irq_status[`IRQ_BIT_MATCH])
		else $error("match flag not set");

	irq_clear_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && addr_i == `ADDR_IRQ_STATUS && wdata_i[`IRQ_BIT_MATCH] &&
		!match_o) |=> !irq_status[`IRQ_BIT_MATCH])
		else $error("match flag not cleared");
	unit_irq_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		unit_event_o |=> irq_status[`IRQ_BIT_UNIT_EVENT])
		else $error("unit event flag not set");

	reserved_zero_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(capture_control & ~`CAP_WRITABLE_MASK) == 16'h0000)
		else $error("reserved capture bits set");
	read_reserved_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(rd_i && addr_i == `ADDR_CAPTURE_CONTROL) |=>
		(rdata_o & ~`CAP_WRITABLE_MASK) == 16'h0000)
		else $error("reserved capture bits read nonzero");
	rdata_idle_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outside read cycle");

	match_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		match_o ##1 pulse_active);
	shadow_load_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		load_event && cmp_shadow_load_sel);
	unit_event_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		unit_event_o);
	irq_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) irq_o);
	zero_load_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		load_event && !cmp_shadow_load_sel);
endmodule // compare_sync_capture_ctrl

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the compare sync and capture control.
// Assumes: Register reads answer in the cycle after the read strobe.
// Notes:   Expected values come from bench-side model words, not the design.
`timescale 1ns/100ps
`include "cmp_cap_cfg.svh"
module testbench;
	logic        clk_i;
	logic        rst_n_i;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [15:0] rdata_o;
	logic [31:0] position_count_i;
	logic        quad_pulse_i;
	logic        sync_out_o;
	logic        match_o;
	logic        capture_tick_o;
	logic        unit_event_o;
	logic        irq_o;
	int          n_fail;
	int          check_count;
	integer      seed;
	logic [31:0] mdl_active;
	logic [31:0] mdl_shadow;
	logic [31:0] got;
	logic [15:0] rv;
	int          n;
	int          k;

	compare_sync_capture_ctrl #(.POS_BITS(32)) u_compare_sync_capture_ctrl (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.position_count_i(position_count_i), .quad_pulse_i(quad_pulse_i),
		.sync_out_o(sync_out_o), .match_o(match_o),
		.capture_tick_o(capture_tick_o), .unit_event_o(unit_event_o),
		.irq_o(irq_o));

	initial clk_i = 1'b0;
	always #2.5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic rd32(input logic [3:0] a, output logic [31:0] d);
		logic [15:0] lo;
		logic [15:0] hi;
		rd_reg(a, lo);
		rd_reg(a + 4'h1, hi);
		d = {hi, lo};
	endtask

	task automatic wr_cmp(input logic [31:0] v);
		wr_reg(`ADDR_COMPARE_VALUE_LO, v[15:0]);
		wr_reg(`ADDR_COMPARE_VALUE_HI, v[31:16]);
	endtask

	task automatic cycle();
		@(posedge clk_i);
		#1;
	endtask

	// Top bit set keeps random compare values away from the idle count of 1
	task automatic run_pulse(input logic pol, input logic [11:0] w);
		int d;
		int c;
		wr_reg(`ADDR_COMPARE_CONTROL, {2'b00, pol, 1'b1, w});
		mdl_active = $random(seed) | 32'h80000000;
		wr_cmp(mdl_active);
		cycle();
		check_val(sync_out_o, pol);
		@(posedge clk_i);
		position_count_i <= mdl_active;
		d = 0;
		do begin cycle(); d++; end while (match_o !== 1'b1 && d < 8);
		check_val(d, 1);
		position_count_i <= 32'h1;
		d = 0;
		do begin cycle(); d++; end while (sync_out_o !== ~pol && d < 8);
		check_val(d, 2);
		c = 0;
		while (sync_out_o === ~pol && c < 20000) begin
			cycle();
			c++;
		end
		check_val(c, (w + 1) * `PULSE_QUANTUM);
		check_val(sync_out_o, pol);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end

	initial begin
		n_fail = 0;
		check_count = 0;
		seed = 32'hced2;
		rst_n_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		position_count_i = 32'h1;
		quad_pulse_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd_reg(`ADDR_COMPARE_CONTROL, rv);
		check_val(rv, `COMPARE_CONTROL_RST);
		rd_reg(`ADDR_CAPTURE_CONTROL, rv);
		check_val(rv, `CAPTURE_CONTROL_RST);
		for (int a = 8; a < 16; a++) begin
			rd_reg(4'(a), rv);
			check_val(rv, 16'h0000);
		end
		wr_reg(`ADDR_CAPTURE_CONTROL, 16'hffff);
		rd_reg(`ADDR_CAPTURE_CONTROL, rv);
		check_val(rv, 16'h807f);
		// Each rate starts from cleared counters so the first gap is exact
		for (int c = 0; c < 8; c++) begin
			wr_reg(`ADDR_CAPTURE_CONTROL, 16'h0000);
			wr_reg(`ADDR_CAPTURE_CONTROL, {1'b1, 8'h00, 3'(c), 4'h0});
			k = 0;
			while (capture_tick_o !== 1'b1 && k < 300) begin cycle(); k++; end
			n = 0;
			do begin cycle(); n++; end
			while (capture_tick_o !== 1'b1 && n < 300);
			check_val(n, 1 << c);
		end
		wr_reg(`ADDR_CAPTURE_CONTROL, 16'h0070);
		k = 0;
		repeat (20) begin cycle(); k += int'(capture_tick_o !== 1'b0); end
		check_val(k, 0);
		for (int u = 0; u < 16; u++) begin
			wr_reg(`ADDR_CAPTURE_CONTROL, 16'h0000);
			wr_reg(`ADDR_CAPTURE_CONTROL,
				{1'b1, 8'h00, 3'($random(seed)), 4'(u)});
			n = 0;
			k = 0;
			while (k == 0 && n < 2100) begin
				@(posedge clk_i);
				quad_pulse_i <= 1'b1;
				n++;
				@(posedge clk_i);
				quad_pulse_i <= 1'b0;
				#1;
				if (unit_event_o === 1'b1) k = n;
			end
			check_val(k, 1 << ((u > 11) ? 11 : u));
		end
		wr_reg(`ADDR_CAPTURE_CONTROL, 16'h0000);
		wr_reg(`ADDR_IRQ_STATUS, 16'h0007);
		wr_reg(`ADDR_IRQ_MASK, 16'h0001);
		run_pulse(1'b0, 12'h000);
		check_val(irq_o, 1'b1);
		wr_reg(`ADDR_IRQ_MASK, 16'h0000);
		check_val(irq_o, 1'b0);
		wr_reg(`ADDR_IRQ_MASK, 16'h0001);
		wr_reg(`ADDR_IRQ_STATUS, 16'h0001);
		check_val(irq_o, 1'b0);
		run_pulse(1'b1, 12'h001);
		run_pulse(1'b0, 12'($random(seed)) & 12'h00f);
		run_pulse(1'b1, 12'hfff);
		wr_reg(`ADDR_COMPARE_CONTROL, 16'h0000);
		@(posedge clk_i);
		position_count_i <= mdl_active;
		k = 0;
		repeat (8) begin cycle(); k += int'(match_o !== 1'b0); end
		check_val(k, 0);
		position_count_i <= 32'h1;
		// Shadowed writes must not reach the active value before a load
		wr_reg(`ADDR_COMPARE_CONTROL, 16'h9000);
		mdl_shadow = $random(seed) | 32'h80000000;
		wr_cmp(mdl_shadow);
		rd32(`ADDR_ACTIVE_CMP_LO, got);
		check_val(got, mdl_active);
		rd32(`ADDR_COMPARE_VALUE_LO, got);
		check_val(got, mdl_shadow);
		wr_reg(`ADDR_IRQ_STATUS, 16'h0007);
		@(posedge clk_i);
		position_count_i <= 32'h0;
		repeat (3) @(posedge clk_i);
		position_count_i <= 32'h1;
		mdl_active = mdl_shadow;
		rd32(`ADDR_ACTIVE_CMP_LO, got);
		check_val(got, mdl_active);
		rd_reg(`ADDR_IRQ_STATUS, rv);
		check_val(rv & 16'h0002, 16'h0002);
		wr_reg(`ADDR_COMPARE_CONTROL, 16'hd000);
		mdl_shadow = $random(seed) | 32'h80000000;
		wr_cmp(mdl_shadow);
		rd32(`ADDR_ACTIVE_CMP_LO, got);
		check_val(got, mdl_active);
		@(posedge clk_i);
		position_count_i <= mdl_active;
		repeat (3) @(posedge clk_i);
		position_count_i <= 32'h1;
		mdl_active = mdl_shadow;
		rd32(`ADDR_ACTIVE_CMP_LO, got);
		check_val(got, mdl_active);
		finish_test();
	end
endmodule // testbench
